// file: hdl/isp_defs.svh
// Constants of the in-circuit programming sequencer
`ifndef ISP_DEFS_SVH
`define ISP_DEFS_SVH

// Timing
`define CLK_PERIOD_NS        50
`define SCLK_PERIOD_NS       400
`define SCLK_HALF_CYC        ((`SCLK_PERIOD_NS / 2) / `CLK_PERIOD_NS)
`define MS_NS                1000000
`define MS_CYC               (`MS_NS / `CLK_PERIOD_NS)
`define START_MIN_MS         16'h001E
`define BLINK_MS             16'h00FA
`define RST_HOLD_MS_DEF      16'h0014
`define RECOV_MS_DEF         16'h01F4

// Link framing
`define LINK_LAST_BIT        3'h7

// Register offsets
`define REG_CTRL             8'h00
`define REG_HOLD             8'h01
`define REG_RECOV            8'h02
`define REG_RANGE            8'h03
`define REG_STATUS           8'h04
`define REG_IRQ_STAT         8'h05
`define REG_IRQ_MASK         8'h06
`define REG_IMAGE_PAGE       4'h1

// Field positions
`define CTRL_AUTO_CLEAR_BIT  0
`define IRQ_DONE_BIT         0
`define IRQ_FAIL_BIT         1

// Image store
`define IMG_DEPTH            16

// Error codes
`define ERR_NONE             8'h00
`define ERR_VERIFY           8'h03
`define ERR_BUSY_STUCK       8'h28
`define ERR_NO_REACT         8'h29

// Target boot commands
`define CMD_ERASE            8'hA7
`define CMD_PROG             8'h41
`define CMD_VERIFY           8'h42
`define RX_DUMMY             8'hFF

`endif

// file: hdl/isp_pkg.sv
// Types of the in-circuit programming sequencer
package isp_pkg;
  `include "isp_defs.svh"

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_type;

  typedef enum logic [2:0] {L_IDLE, L_LOW, L_HIGH, L_CHECK, L_WAIT} link_state_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RESET, ST_RECOVER, ST_CHECK, ST_ISSUE, ST_WAIT
  } seq_state_type;

  typedef enum logic [2:0] {
    STEP_ERASE, STEP_PROG_CMD, STEP_PROG_DATA, STEP_VER_CMD, STEP_VER_DATA
  } step_type;

  typedef struct packed {
    link_state_type st;
    logic [2:0]     bit_cnt;
    logic [3:0]     div;
    logic [7:0]     sh;
    logic [7:0]     rx;
    logic           sclk;
    logic           txd;
    logic           done;
    logic           err;
  } link_regs_type;
endpackage

// file: hdl/isp_serial_programmer_seq.sv
// Stand-alone erase, program and verify sequencer for a serial boot target
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "isp_defs.svh"
module isp_serial_programmer_seq
  import isp_pkg::*;
#(
  parameter int MS_CYCLES = `MS_CYC
)
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // Register port
  input  wire reg_req_type reg_req_i,
  output logic [15:0]      reg_rdata_o,
  output logic             irq_o,
  // Front panel and remote control
  input  wire logic        start_btn_i,
  input  wire logic        remote_start_i,
  output logic             remote_busy_o,
  output logic             remote_ok_o,
  output logic             led_green_o,
  output logic             led_red_o,
  // Target link
  output logic             target_rst_n_o,
  output logic             sclk_o,
  output logic             txd_o,
  input  wire logic        target_busy_i,
  input  wire logic        rxd_i
);

  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  typedef struct packed {
    logic                          btn1;
    logic                          btn2;
    logic                          btn3;
    logic                          rem1;
    logic                          rem2;
    logic                          rem3;
    logic                          busy1;
    logic                          busy2;
    logic                          rxd1;
    logic                          rxd2;
    seq_state_type                 st;
    step_type                      step;
    logic [3:0]                    idx;
    logic [15:0]                   ms_cnt;
    logic                          ms_tick;
    logic [15:0]                   tmr;
    logic [15:0]                   rem_ms;
    logic [15:0]                   blink_ms;
    logic                          blink;
    logic                          link_start;
    logic [7:0]                    tx_byte;
    logic                          auto_clear;
    logic [15:0]                   hold_ms;
    logic [15:0]                   recov_ms;
    logic [3:0]                    rng_lo;
    logic [3:0]                    rng_hi;
    logic [1:0]                    irq_stat;
    logic [1:0]                    irq_mask;
    logic [`IMG_DEPTH-1:0][7:0]    image;
    logic                          busy_out;
    logic                          ok_out;
    logic                          failed;
    logic                          done_once;
    logic                          rst_n_out;
    logic [7:0]                    err_code;
    logic [15:0]                   rdata;
  } seq_regs_type;

  seq_regs_type s;
  seq_regs_type n;
  logic         link_done;
  logic         link_err;
  logic [7:0]   link_rx;
  logic         btn_rise;
  logic         rem_fall_ok;
  logic         start_job;

  function automatic logic is_image(input logic [7:0] addr);
    is_image = (addr[7:4] == `REG_IMAGE_PAGE);
  endfunction

  // -----------------------------------------------------------------
  // Job launch
  // -----------------------------------------------------------------
  assign btn_rise    = s.btn2 && !s.btn3;
  assign rem_fall_ok = s.rem3 && !s.rem2 && (s.rem_ms >= `START_MIN_MS);
  assign start_job   = (s.st == ST_IDLE) && (btn_rise || rem_fall_ok);

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    logic       fin;
    logic       fin_ok;
    logic [7:0] fin_code;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    fin      = 1'b0;
    fin_ok   = 1'b0;
    fin_code = `ERR_NONE;
    irq_set  = 2'h0;
    irq_clr  = 2'h0;
    n        = s;

    // Pin synchronisers
    n.btn1  = start_btn_i;
    n.btn2  = s.btn1;
    n.btn3  = s.btn2;
    n.rem1  = remote_start_i;
    n.rem2  = s.rem1;
    n.rem3  = s.rem2;
    n.busy1 = target_busy_i;
    n.busy2 = s.busy1;
    n.rxd1  = rxd_i;
    n.rxd2  = s.rxd1;

    // Millisecond time base
    n.ms_tick = (s.ms_cnt == MS_LAST);
    n.ms_cnt  = n.ms_tick ? 16'h0000 : s.ms_cnt + 16'h0001;

    // Remote pulse length, saturating
    if (s.rem2) begin
      if (s.ms_tick && s.rem_ms != 16'hFFFF) begin
        n.rem_ms = s.rem_ms + 16'h0001;
      end
    end else begin
      n.rem_ms = 16'h0000;
    end

    // Blink while a job runs
    if (s.busy_out && s.ms_tick) begin
      n.blink_ms = s.blink_ms + 16'h0001;
      if (s.blink_ms == `BLINK_MS - 16'h0001) begin
        n.blink_ms = 16'h0000;
        n.blink    = !s.blink;
      end
    end

    n.link_start = 1'b0;

    case (s.st)
      ST_IDLE: begin
        if (start_job) begin
          n.st        = ST_RESET;
          n.tmr       = 16'h0000;
          n.busy_out  = 1'b1;
          n.rst_n_out = 1'b0;
          n.failed    = 1'b0;
          n.blink     = 1'b1;
          n.blink_ms  = 16'h0000;
          // Time base restarts so the reset hold is never cut short
          n.ms_cnt    = 16'h0000;
          n.ms_tick   = 1'b0;
          n.idx       = s.rng_lo;
          n.step      = s.auto_clear ? STEP_ERASE : STEP_PROG_CMD;
        end
      end
      ST_RESET: begin
        if (s.tmr >= s.hold_ms) begin
          n.rst_n_out = 1'b1;
          n.tmr       = 16'h0000;
          n.st        = ST_RECOVER;
        end else if (s.ms_tick) begin
          n.tmr = s.tmr + 16'h0001;
        end
      end
      ST_RECOVER: begin
        if (s.tmr >= s.recov_ms) begin
          n.st = ST_CHECK;
        end else if (s.ms_tick) begin
          n.tmr = s.tmr + 16'h0001;
        end
      end
      ST_CHECK: begin
        if (s.busy2) begin
          fin      = 1'b1;
          fin_code = `ERR_BUSY_STUCK;
        end else begin
          n.st = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        n.link_start = 1'b1;
        n.st         = ST_WAIT;
        case (s.step)
          STEP_ERASE:     n.tx_byte = `CMD_ERASE;
          STEP_PROG_CMD:  n.tx_byte = `CMD_PROG;
          STEP_PROG_DATA: n.tx_byte = s.image[s.idx];
          STEP_VER_CMD:   n.tx_byte = `CMD_VERIFY;
          default:        n.tx_byte = `RX_DUMMY;
        endcase
      end
      ST_WAIT: begin
        if (link_done) begin
          n.st = ST_ISSUE;
          if (link_err) begin
            fin      = 1'b1;
            fin_code = `ERR_NO_REACT;
          end else begin
            case (s.step)
              STEP_ERASE: begin
                n.step = STEP_PROG_CMD;
              end
              STEP_PROG_CMD: begin
                n.step = STEP_PROG_DATA;
                n.idx  = s.rng_lo;
              end
              STEP_PROG_DATA: begin
                if (s.idx == s.rng_hi) begin
                  n.step = STEP_VER_CMD;
                end else begin
                  n.idx = s.idx + 4'h1;
                end
              end
              STEP_VER_CMD: begin
                n.step = STEP_VER_DATA;
                n.idx  = s.rng_lo;
              end
              default: begin
                if (link_rx != s.image[s.idx]) begin
                  fin      = 1'b1;
                  fin_code = `ERR_VERIFY;
                end else if (s.idx == s.rng_hi) begin
                  fin    = 1'b1;
                  fin_ok = 1'b1;
                end else begin
                  n.idx = s.idx + 4'h1;
                end
              end
            endcase
          end
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // Job end
    if (fin) begin
      n.st        = ST_IDLE;
      n.busy_out  = 1'b0;
      n.ok_out    = fin_ok;
      n.failed    = !fin_ok;
      n.done_once = 1'b1;
      n.err_code  = fin_code;
      irq_set[`IRQ_DONE_BIT] = 1'b1;
      irq_set[`IRQ_FAIL_BIT] = !fin_ok;
    end

    // Register writes
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        `REG_CTRL:     n.auto_clear = reg_req_i.wdata[`CTRL_AUTO_CLEAR_BIT];
        `REG_HOLD:     n.hold_ms    = reg_req_i.wdata;
        `REG_RECOV:    n.recov_ms   = reg_req_i.wdata;
        `REG_IRQ_STAT: irq_clr      = reg_req_i.wdata[1:0];
        `REG_IRQ_MASK: n.irq_mask   = reg_req_i.wdata[1:0];
        `REG_RANGE: begin
          n.rng_lo = reg_req_i.wdata[3:0];
          n.rng_hi = reg_req_i.wdata[7:4];
        end
        default: begin
          if (is_image(reg_req_i.addr)) begin
            n.image[reg_req_i.addr[3:0]] = reg_req_i.wdata[7:0];
          end
        end
      endcase
    end
    // Set wins over clear
    n.irq_stat = (s.irq_stat & ~irq_clr) | irq_set;

    // Register reads, data in the next cycle only
    n.rdata = 16'h0000;
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        `REG_CTRL:     n.rdata = {15'h0000, s.auto_clear};
        `REG_HOLD:     n.rdata = s.hold_ms;
        `REG_RECOV:    n.rdata = s.recov_ms;
        `REG_RANGE:    n.rdata = {8'h00, s.rng_hi, s.rng_lo};
        `REG_IRQ_STAT: n.rdata = {14'h0000, s.irq_stat};
        `REG_IRQ_MASK: n.rdata = {14'h0000, s.irq_mask};
        `REG_STATUS: begin
          n.rdata = {s.err_code, 4'h0, s.done_once, s.failed, s.ok_out, s.busy_out};
        end
        default: begin
          if (is_image(reg_req_i.addr)) begin
            n.rdata = {8'h00, s.image[reg_req_i.addr[3:0]]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '{st: ST_IDLE, step: STEP_ERASE, hold_ms: `RST_HOLD_MS_DEF,
             recov_ms: `RECOV_MS_DEF, rng_hi: 4'hF, rst_n_out: 1'b1,
             default: '0};
    end else begin
      s <= n;
    end
  end

  // -----------------------------------------------------------------
  // Byte engine
  // -----------------------------------------------------------------
  sync_byte_link u_link (
    .mclk_i    (mclk_i),
    .nrst_i    (nrst_i),
    .start_i   (s.link_start),
    .tx_byte_i (s.tx_byte),
    .done_o    (link_done),
    .err_o     (link_err),
    .rx_byte_o (link_rx),
    .busy_i    (s.busy2),
    .rxd_i     (s.rxd2),
    .sclk_o    (sclk_o),
    .txd_o     (txd_o)
  );

  assign reg_rdata_o    = s.rdata;
  assign irq_o          = |(s.irq_stat & s.irq_mask);
  assign remote_busy_o  = s.busy_out;
  assign remote_ok_o    = s.ok_out;
  assign target_rst_n_o = s.rst_n_out;
  assign led_green_o    = s.busy_out ? s.blink : (s.done_once && !s.failed);
  assign led_red_o      = !s.busy_out && s.done_once && s.failed;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  property p_busy_on_start;
    @(posedge mclk_i) disable iff (!nrst_i)
    start_job |=> (remote_busy_o && !target_rst_n_o);
  endproperty
  a_busy_on_start: assert property (p_busy_on_start)
    else $error("busy or target reset missing at job start");

  property p_remote_edge;
    @(posedge mclk_i) disable iff (!nrst_i)
    (start_job && !btn_rise) |-> (s.rem3 && !s.rem2 && s.rem_ms >= `START_MIN_MS);
  endproperty
  a_remote_edge: assert property (p_remote_edge)
    else $error("remote job started without a qualifying falling edge");

  property p_erase_option;
    @(posedge mclk_i) disable iff (!nrst_i)
    (s.st == ST_ISSUE && s.step == STEP_ERASE) |-> s.auto_clear;
  endproperty
  a_erase_option: assert property (p_erase_option)
    else $error("erase issued without automatic clear");

  property p_quiet_recovery;
    @(posedge mclk_i) disable iff (!nrst_i)
    (s.st == ST_RECOVER) |-> (sclk_o && target_rst_n_o && !s.link_start);
  endproperty
  a_quiet_recovery: assert property (p_quiet_recovery)
    else $error("serial activity during recovery wait");

  property p_stuck_busy;
    @(posedge mclk_i) disable iff (!nrst_i)
    (s.st == ST_CHECK && s.busy2) |=> (s.err_code == `ERR_BUSY_STUCK && !remote_busy_o);
  endproperty
  a_stuck_busy: assert property (p_stuck_busy)
    else $error("busy target did not abort with code 40");

  property p_no_react_abort;
    @(posedge mclk_i) disable iff (!nrst_i)
    (s.st == ST_WAIT && link_done && link_err) |=> (s.err_code == `ERR_NO_REACT && led_red_o);
  endproperty
  a_no_react_abort: assert property (p_no_react_abort)
    else $error("busy reaction abort not reported as code 41");

  property p_result_valid;
    @(posedge mclk_i) disable iff (!nrst_i)
    $fell(remote_busy_o) |-> (remote_ok_o == !s.failed && led_red_o == s.failed);
  endproperty
  a_result_valid: assert property (p_result_valid)
    else $error("result output does not match job outcome");

  property p_no_red_busy;
    @(posedge mclk_i) disable iff (!nrst_i)
    remote_busy_o |-> !led_red_o;
  endproperty
  a_no_red_busy: assert property (p_no_red_busy)
    else $error("red shown while job running");
endmodule

// file: hdl/sync_byte_link.sv
// Byte engine for the clocked synchronous target link
`timescale 1ns/1ps
module sync_byte_link
  import isp_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  // Byte request
  input  wire logic       start_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            done_o,
  output logic            err_o,
  output logic [7:0]      rx_byte_o,
  // Link pins, inputs already synchronised
  input  wire logic       busy_i,
  input  wire logic       rxd_i,
  output logic            sclk_o,
  output logic            txd_o
);

  localparam logic [3:0] HALF_LAST = 4'(`SCLK_HALF_CYC - 1);

  link_regs_type s;
  link_regs_type n;
  logic [3:0]    falls;

  always_comb begin
    n      = s;
    n.done = 1'b0;
    n.err  = 1'b0;
    case (s.st)
      L_IDLE: begin
        n.sclk = 1'b1;
        if (start_i) begin
          n.sh      = tx_byte_i;
          n.txd     = tx_byte_i[0];
          n.sclk    = 1'b0;
          n.div     = 4'h0;
          n.bit_cnt = 3'h0;
          n.st      = L_LOW;
        end
      end
      L_LOW: begin
        n.div = s.div + 4'h1;
        if (s.div == HALF_LAST) begin
          n.div  = 4'h0;
          n.sclk = 1'b1;
          n.rx   = {rxd_i, s.rx[7:1]};
          n.st   = L_HIGH;
        end
      end
      L_HIGH: begin
        n.div = s.div + 4'h1;
        if (s.div == HALF_LAST) begin
          n.div = 4'h0;
          if (s.bit_cnt == 3'h0) begin
            n.st = L_CHECK;
          end else if (s.bit_cnt == `LINK_LAST_BIT) begin
            n.st = L_WAIT;
          end else begin
            n.bit_cnt = s.bit_cnt + 3'h1;
            n.sh      = s.sh >> 1;
            n.txd     = s.sh[1];
            n.sclk    = 1'b0;
            n.st      = L_LOW;
          end
        end
      end
      L_CHECK: begin
        n.div = s.div + 4'h1;
        if (s.div == HALF_LAST) begin
          n.div = 4'h0;
          if (!busy_i) begin
            n.err  = 1'b1;
            n.done = 1'b1;
            n.st   = L_IDLE;
          end else begin
            n.bit_cnt = 3'h1;
            n.sh      = s.sh >> 1;
            n.txd     = s.sh[1];
            n.sclk    = 1'b0;
            n.st      = L_LOW;
          end
        end
      end
      L_WAIT: begin
        if (!busy_i) begin
          n.done = 1'b1;
          n.st   = L_IDLE;
        end
      end
      default: begin
        n.st = L_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '{st: L_IDLE, sclk: 1'b1, default: '0};
    end else begin
      s <= n;
    end
  end

  assign done_o    = s.done;
  assign err_o     = s.err;
  assign rx_byte_o = s.rx;
  assign sclk_o    = s.sclk;
  assign txd_o     = s.txd;

  // Falling clock edges per byte
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      falls <= 4'h0;
    end else if (s.st == L_IDLE) begin
      falls <= start_i ? 4'h1 : 4'h0;
    end else if (s.sclk && !n.sclk) begin
      falls <= falls + 4'h1;
    end
  end

  property p_idle_high;
    @(posedge mclk_i) disable iff (!nrst_i)
    (s.st == L_IDLE) |-> sclk_o;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("serial clock not high while idle");

  property p_no_react;
    @(posedge mclk_i) disable iff (!nrst_i)
    (s.st == L_CHECK && s.div == HALF_LAST && !busy_i) |=> (done_o && err_o);
  endproperty
  a_no_react: assert property (p_no_react)
    else $error("missing busy reaction not flagged");

  property p_eight_clocks;
    @(posedge mclk_i) disable iff (!nrst_i)
    (done_o && !err_o) |-> (falls == 4'h8);
  endproperty
  a_eight_clocks: assert property (p_eight_clocks)
    else $error("byte did not carry eight clocks");

  property p_data_stable;
    @(posedge mclk_i) disable iff (!nrst_i)
    $rose(sclk_o) |-> $stable(txd_o);
  endproperty
  a_data_stable: assert property (p_data_stable)
    else $error("data changed on rising clock");
endmodule

// file: testbench/target_boot_model.sv
// Behavioural serial boot firmware of the target
`timescale 1ns/1ps
module target_boot_model (
  // Clock and link
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       sclk_i,
  input  wire logic       txd_i,
  // Fault controls
  input  wire logic       stuck_i,
  input  wire logic       mute_i,
  // Observation
  output logic            busy_o,
  output logic            rxd_o,
  output logic [7:0]      first_o,
  output logic [3:0]      count_o
);
  logic [7:0] mem [16];
  logic [7:0] sh;
  logic [7:0] out;
  logic [3:0] bits;
  logic [3:0] wi;
  logic [2:0] hold;
  logic       sclk_d;
  logic       pmode;
  logic       vmode;

  initial begin
    busy_o = 1'b0;
    rxd_o = 1'b0;
    sclk_d = 1'b1;
  end

  always @(posedge mclk_i) begin
    sclk_d <= sclk_i;
    if (!rst_n_i) begin
      bits <= 4'h0;
      count_o <= 4'h0;
      hold <= 3'h0;
      pmode <= 1'b0;
      vmode <= 1'b0;
      busy_o <= stuck_i;
    end else if (bits == 4'h8) begin
      // Stay busy a while, then take the byte
      hold <= hold + 3'h1;
      if (hold == 3'h5) begin
        busy_o <= 1'b0;
        bits <= 4'h0;
        hold <= 3'h0;
        count_o <= count_o + 4'h1;
        if (count_o == 4'h0) first_o <= sh;
        if (vmode) begin
          out <= mem[wi];
          wi <= wi + 4'h1;
        end else if (sh == 8'h42) begin
          vmode <= 1'b1;
          out <= mem[0];
          wi <= 4'h1;
        end else if (pmode) begin
          mem[wi] <= sh;
          wi <= wi + 4'h1;
        end else if (sh == 8'h41) begin
          pmode <= 1'b1;
          wi <= 4'h0;
        end
      end
    end else if (sclk_i && !sclk_d) begin
      sh <= {txd_i, sh[7:1]};
      bits <= bits + 4'h1;
      if (bits == 4'h0 && !mute_i) busy_o <= 1'b1;
    end else if (!sclk_i && sclk_d) begin
      rxd_o <= out[bits[2:0]];
    end else if (sclk_i && bits == 4'h0) begin
      rxd_o <= ~rxd_o;
    end
  end
endmodule

// file: testbench/test_isp_serial_programmer_seq.sv
// Self-checking bench of the programming sequencer
`timescale 1ns/1ps
`include "isp_defs.svh"
module test_isp_serial_programmer_seq;
  import isp_pkg::*;
  logic        mclk_i = 1'b0;
  logic        nrst_i;
  reg_req_type req;
  logic [15:0] rdata;
  logic        irq, btn, rem, rbusy, rok, lg, lr, trst, sclk, txd, tbusy, rxd, stuck, mute;
  logic [7:0]  first;
  logic [3:0]  cnt;
  int          err_total = 0;
  int          checks = 0;
  int          low, gap;
  logic [7:0]  ra [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
  logic [15:0] rv [8] = '{16'h0000, 16'h0014, 16'h01F4, 16'h00F0, 16'h0000, 16'h0000,
                          16'h0000, 16'h0000};

  always #25 mclk_i = ~mclk_i;

  isp_serial_programmer_seq #(.MS_CYCLES(20)) dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .irq_o(irq), .start_btn_i(btn),
    .remote_start_i(rem), .remote_busy_o(rbusy), .remote_ok_o(rok), .led_green_o(lg),
    .led_red_o(lr), .target_rst_n_o(trst), .sclk_o(sclk), .txd_o(txd),
    .target_busy_i(tbusy), .rxd_i(rxd));

  target_boot_model tgt_u (.mclk_i(mclk_i), .rst_n_i(trst), .sclk_i(sclk), .txd_i(txd),
    .stuck_i(stuck), .mute_i(mute), .busy_o(tbusy), .rxd_o(rxd), .first_o(first),
    .count_o(cnt));

  task automatic finish_test;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk_i);
    req <= '{a, d, 1'b0, 1'b0};
    @(posedge mclk_i);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge mclk_i);
    req.rd <= 1'b0;
    @(negedge mclk_i);
    chk(rdata & m, e);
    @(posedge mclk_i);
  endtask

  task automatic start(input logic remote, input int ms);
    if (remote) begin
      rem <= 1'b1;
      repeat (ms * 20) @(posedge mclk_i);
      chk(rbusy, 1'b0);
      rem <= 1'b0;
    end else begin
      btn <= 1'b1;
      repeat (3) @(posedge mclk_i);
      btn <= 1'b0;
    end
  endtask

  task automatic run;
    for (int n = 0; n < 8 && rbusy !== 1'b1; n++) @(posedge mclk_i);
    chk(rbusy, 1'b1);
    chk({lg, lr}, 2'b10);
    low = 0;
    gap = 0;
    while (trst !== 1'b1 && low < 2000) begin
      @(posedge mclk_i);
      low++;
    end
    while (sclk !== 1'b0 && rbusy === 1'b1 && gap < 2000) begin
      @(posedge mclk_i);
      gap++;
    end
    for (int n = 0; n < 5000 && rbusy !== 1'b0; n++) @(posedge mclk_i);
    chk(rbusy, 1'b0);
    chk(low >= 40 && low <= 61, 1'b1);
    chk(gap >= 60 && gap <= 70, 1'b1);
  endtask

  initial begin
    #1_000_000;
    err_total++;
    finish_test;
  end

  initial begin
    nrst_i = 1'b0;
    req = '0;
    {btn, rem, stuck, mute} = 4'h0;
    repeat (8) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    for (int i = 0; i < 8; i++) rchk(ra[i], 16'hFFFF, rv[i]);
    chk({rok, lg, lr, trst, sclk, irq}, 6'h06);
    wr(`REG_HOLD, 16'h0002);
    wr(`REG_RECOV, 16'h0003);
    wr(`REG_RANGE, 16'h0010);
    wr(8'h10, 16'h005A);
    wr(8'h11, 16'h00C3);
    wr(`REG_IRQ_MASK, 16'h0003);
    rchk(8'h11, 16'hFFFF, 16'h00C3);
    start(1'b0, 0);
    run();
    chk(first, `CMD_PROG);
    chk(cnt, 4'h6);
    chk({rok, lg, lr}, 3'b110);
    rchk(`REG_STATUS, 16'hFF07, 16'h0002);
    chk(irq, 1'b1);
    wr(`REG_IRQ_STAT, 16'h0003);
    @(posedge mclk_i);
    chk(irq, 1'b0);
    wr(`REG_CTRL, 16'h0001);
    start(1'b1, 35);
    run();
    chk(first, `CMD_ERASE);
    chk(cnt, 4'h7);
    start(1'b1, 10);
    repeat (10) @(posedge mclk_i);
    chk(rbusy, 1'b0);
    stuck <= 1'b1;
    start(1'b0, 0);
    run();
    rchk(`REG_STATUS, 16'hFF07, 16'h2804);
    chk({rok, lg, lr}, 3'b001);
    stuck <= 1'b0;
    mute <= 1'b1;
    start(1'b0, 0);
    run();
    rchk(`REG_STATUS, 16'hFF07, 16'h2904);
    chk({rok, lg, lr}, 3'b001);
    finish_test;
  end
endmodule
